// *** rtl/fcbw_pkg.sv ***
// Purpose: shared constants and types for the feature configuration bank
// Assumes: 8-bit register map reached through the serial front end
// Notes: bit positions are fixed by the register layout
package fcbw_pkg;
  // register map
  localparam logic [7:0] ADDR_SAMPLE_FIRST = 8'h02;
  localparam logic [7:0] ADDR_SAMPLE_LAST = 8'h07;
  localparam logic [7:0] ADDR_STATUS_ONE = 8'h08;
  localparam logic [7:0] ADDR_STATUS_TWO = 8'h09;
  localparam logic [7:0] ADDR_IF_CFG = 8'h0D;
  localparam logic [7:0] ADDR_BURST_CFG = 8'h0E;
  localparam logic [7:0] RESET_IF_CFG = 8'h00;
  localparam logic [7:0] RESET_BURST_CFG = 8'h00;
  localparam logic [7:0] IF_CFG_WMASK = 8'hF8;
  localparam logic [7:0] READ_UNMAPPED = 8'h00;
  // interface_and_sniff_config fields
  localparam int BIT_CAPTURE_HOLD = 3;
  localparam int BIT_SNIFF_REARM = 4;
  localparam int BIT_THREE_WIRE = 5;
  localparam int BIT_TWO_WIRE_SEL = 6;
  localparam int BIT_FOUR_WIRE_SEL = 7;
  // burst_and_feature_config fields
  localparam int BIT_BURST_WRAP = 0;
  localparam int BIT_LONG_BURST = 1;
  localparam int BIT_CLEAR_ON_WRITE = 4;
  localparam int BIT_STREAM = 5;
  // status two: detect flag position
  localparam int BIT_DETECT_FLAG = 7;
  localparam int FIFO_DEPTH_DEF = 32;
  localparam int SAMPLE_W = 48;

  typedef enum logic [1:0] {
    LINK_TWO_WIRE,
    LINK_FOUR_WIRE,
    LINK_THREE_WIRE
  } link_e;

  typedef struct packed {
    logic [15:0] z;
    logic [15:0] y;
    logic [15:0] x;
  } sample_s;

  typedef struct packed {
    logic start;
    logic rd;
    logic wr;
    link_e link;
    logic [7:0] addr;
    logic [7:0] wdata;
  } access_s;
endpackage

// *** rtl/burst_addr_step.sv ***
// Purpose: next burst address with wrap back to the first sample byte
// Assumes: purely combinational, same clock as the register bank
// Notes: wrap point is the last sample byte or the second status register
`timescale 1ns/1ps
module burst_addr_step
  import fcbw_pkg::*;
(
  // current address and wrap choice
  input wire logic [7:0] addr,
  input wire logic wrap_status,
  // following address
  output logic [7:0] next_addr
);
  always_comb begin
    next_addr = addr + 8'h01;
    if (!wrap_status && addr == ADDR_SAMPLE_LAST) begin
      next_addr = ADDR_SAMPLE_FIRST;
    end
    if (wrap_status && addr == ADDR_STATUS_TWO) begin
      next_addr = ADDR_SAMPLE_FIRST;
    end
  end
endmodule

// *** rtl/feature_config_burst_wrap.sv ***
// Purpose: interface select, sniff capture and burst wrap configuration
// Assumes: accesses arrive decoded from the serial front end on CLK
// Notes: sample fifo and sniff detect state live here with the config
// How it works
// - no select bit set: samples never reach the result bytes
// - neither two- nor four-wire selected: power-up interface stays usable
// - capture hold set: fifo stops accepting after a detect event
// - capture hold clear: fifo keeps capturing after a detect event
// - detector ignores events after a detect until it is re-armed
// - re-arm set: clearing the flag re-arms the detector
// - re-arm clear: detector halted until concurrent mode is left
// - bit five picks three-wire over four-wire serial
// - two-wire select shuts off four-wire serial access
// - four-wire select shuts off two-wire access
// - wrap bit clear: burst goes from 0x07 back to 0x02
// - wrap bit set: burst goes from 0x09 back to 0x02
// - long-burst clear: one burst pops one six-byte sample
// - long-burst set: up to 32 samples popped per burst
// - stream mode: full fifo drops oldest for newest sample
// - serial modes clear flags by writing 0x09, reads do not
`timescale 1ns/1ps
module feature_config_burst_wrap
  import fcbw_pkg::*;
#(
  parameter int FIFO_DEPTH = FIFO_DEPTH_DEF
)
(
  // clock, reset, enable
  input wire logic CLK,
  input wire logic RST,
  input wire logic CE,
  // power-up interface strap pin, high for two-wire
  input wire logic STRAP_TWO_WIRE,
  // register access from the serial front end
  input wire access_s ACC,
  output logic [7:0] RD_DATA,
  output logic RD_VALID,
  output logic ACC_REFUSED,
  // sampling and sniff engines
  input wire logic SAMPLE_VALID,
  input wire sample_s SAMPLE,
  input wire logic FIFO_ENABLE,
  input wire logic CONCURRENT_MODE,
  input wire logic SNIFF_EVENT,
  // other status bits
  input wire logic [7:0] STATUS_ONE_IN,
  input wire logic [6:0] STATUS_TWO_IN,
  // configuration and state out
  output logic THREE_WIRE,
  output logic DETECT_FLAG,
  output logic INT_CLEAR,
  output logic FIFO_EMPTY,
  output logic FIFO_FULL
);
  localparam int PW = $clog2(FIFO_DEPTH);
  localparam logic [PW:0] DEPTH_N = (PW + 1)'(FIFO_DEPTH);
  localparam logic [PW:0] ONE_N = (PW + 1)'(1);
  localparam logic [PW-1:0] ONE_P = PW'(1);

  typedef enum logic {
    DET_ARMED,
    DET_HALTED
  } det_e;

  typedef struct packed {
    logic [2:0] strap_sync;
    logic [2:0] strap_fill;
    logic strap_done;
    logic strap_two;
    logic [7:0] if_cfg;
    logic [7:0] burst_cfg;
    det_e det;
    logic flag;
    logic [FIFO_DEPTH-1:0][SAMPLE_W-1:0] mem;
    logic [PW-1:0] rd_ptr;
    logic [PW-1:0] wr_ptr;
    logic [PW:0] count;
    sample_s result;
    logic [7:0] addr;
    logic [PW:0] pops;
    logic [7:0] rdata;
    logic rvalid;
    logic refused;
    logic int_clear;
  } state_s;

  state_s s_ff;
  state_s nxt_s;
  logic [7:0] step_addr;
  logic [7:0] cur_addr;

  // byte of a sample picked by register address
  function automatic logic [7:0] sample_byte(input sample_s smp,
                                             input logic [7:0] a);
    logic [7:0] idx;
    idx = a - ADDR_SAMPLE_FIRST;
    return smp[idx[2:0]*8 +: 8];
  endfunction

  // whether a given link may reach the registers
  function automatic logic link_open(input link_e lk, input logic [7:0] cfg,
                                     input logic strap_two);
    logic two_sel;
    logic four_sel;
    two_sel = cfg[BIT_TWO_WIRE_SEL];
    four_sel = cfg[BIT_FOUR_WIRE_SEL];
    if (!two_sel && !four_sel) begin
      return strap_two ? (lk == LINK_TWO_WIRE) : (lk != LINK_TWO_WIRE);
    end
    if (lk == LINK_TWO_WIRE) begin
      return !four_sel;
    end
    return !two_sel;
  endfunction

  // address in flight: a start carries its own address
  assign cur_addr = ACC.start ? ACC.addr : s_ff.addr;

  burst_addr_step u_step (
    .addr(cur_addr),
    .wrap_status(s_ff.burst_cfg[BIT_BURST_WRAP]),
    .next_addr(step_addr)
  );

  always_comb begin
    logic ok;
    logic rd;
    logic wr;
    logic any_sel;
    logic do_clear;
    logic do_pop;
    logic do_push;
    logic fifo_live;
    logic [PW:0] cnt;
    logic [PW:0] pops;
    ok = 1'b0;
    rd = 1'b0;
    wr = 1'b0;
    any_sel = 1'b0;
    do_clear = 1'b0;
    do_pop = 1'b0;
    do_push = 1'b0;
    fifo_live = 1'b0;
    cnt = '0;
    pops = '0;
    nxt_s = s_ff;
    nxt_s.rvalid = 1'b0;
    nxt_s.refused = 1'b0;
    nxt_s.int_clear = 1'b0;

    // reset zeros in the stages must not pass for a sampled strap
    nxt_s.strap_sync = {s_ff.strap_sync[1:0], STRAP_TWO_WIRE};
    nxt_s.strap_fill = {s_ff.strap_fill[1:0], 1'b1};
    if (!s_ff.strap_done && s_ff.strap_fill[2]
        && s_ff.strap_sync[1] == s_ff.strap_sync[2]) begin
      nxt_s.strap_done = 1'b1;
      nxt_s.strap_two = s_ff.strap_sync[2];
    end
    ok = link_open(ACC.link, s_ff.if_cfg, s_ff.strap_two);
    rd = ACC.rd && ok;
    wr = ACC.wr && ok;
    nxt_s.refused = (ACC.rd || ACC.wr) && !ok;
    any_sel = s_ff.if_cfg[BIT_TWO_WIRE_SEL] || s_ff.if_cfg[BIT_FOUR_WIRE_SEL]
      || s_ff.if_cfg[BIT_THREE_WIRE];
    fifo_live = FIFO_ENABLE && s_ff.count != '0;
    pops = ACC.start ? '0 : s_ff.pops;

    if (ACC.start) begin
      nxt_s.addr = ACC.addr;
      nxt_s.pops = '0;
    end

    if (rd || wr) begin
      nxt_s.addr = step_addr;
    end

    if (rd) begin
      nxt_s.rvalid = 1'b1;
      case (cur_addr)
        ADDR_SAMPLE_FIRST, 8'(ADDR_SAMPLE_FIRST + 8'h01),
        8'(ADDR_SAMPLE_FIRST + 8'h02), 8'(ADDR_SAMPLE_FIRST + 8'h03),
        8'(ADDR_SAMPLE_FIRST + 8'h04), ADDR_SAMPLE_LAST: begin
          nxt_s.rdata = fifo_live
            ? sample_byte(sample_s'(s_ff.mem[s_ff.rd_ptr]), cur_addr)
            : sample_byte(s_ff.result, cur_addr);
        end
        ADDR_STATUS_ONE: nxt_s.rdata = STATUS_ONE_IN;
        ADDR_STATUS_TWO: nxt_s.rdata = {s_ff.flag, STATUS_TWO_IN};
        ADDR_IF_CFG: nxt_s.rdata = s_ff.if_cfg;
        ADDR_BURST_CFG: nxt_s.rdata = s_ff.burst_cfg;
        default: nxt_s.rdata = READ_UNMAPPED;
      endcase
      // one pop, or up to depth when long
      if (cur_addr == ADDR_SAMPLE_LAST && fifo_live) begin
        if (pops == '0 ||
            (s_ff.burst_cfg[BIT_LONG_BURST] && pops < DEPTH_N)) begin
          do_pop = 1'b1;
          nxt_s.pops = pops + ONE_N;
        end
      end
    end

    if (wr) begin
      case (cur_addr)
        // low bits kept at zero whatever is written
        ADDR_IF_CFG: nxt_s.if_cfg = ACC.wdata & IF_CFG_WMASK;
        ADDR_BURST_CFG: nxt_s.burst_cfg = ACC.wdata;
        default: nxt_s.burst_cfg = s_ff.burst_cfg;
      endcase
    end

    // serial links clear by write only; two-wire per config
    if (ACC.link == LINK_TWO_WIRE && !s_ff.burst_cfg[BIT_CLEAR_ON_WRITE]) begin
      do_clear = rd && cur_addr == ADDR_STATUS_TWO;
    end else begin
      do_clear = wr && cur_addr == ADDR_STATUS_TWO;
    end
    nxt_s.int_clear = do_clear;
    if (do_clear) begin
      nxt_s.flag = 1'b0;
    end

    // sniff detector; while armed, an event in the clear cycle wins
    case (s_ff.det)
      DET_ARMED: begin
        if (CONCURRENT_MODE && SNIFF_EVENT) begin
          nxt_s.flag = 1'b1;
          nxt_s.det = DET_HALTED;
        end
      end
      DET_HALTED: begin
        if (!CONCURRENT_MODE) begin
          nxt_s.det = DET_ARMED;
        end else if (do_clear && s_ff.if_cfg[BIT_SNIFF_REARM]) begin
          nxt_s.det = DET_ARMED;
        end
      end
      default: nxt_s.det = DET_ARMED;
    endcase

    // samples dropped with no interface selected
    if (SAMPLE_VALID && any_sel) begin
      if (!FIFO_ENABLE) begin
        nxt_s.result = SAMPLE;
      end else if (!(s_ff.if_cfg[BIT_CAPTURE_HOLD] && s_ff.flag)) begin
        // hold only while flag raised and hold set
        do_push = 1'b1;
      end
    end

    cnt = s_ff.count;
    if (do_pop) begin
      nxt_s.rd_ptr = s_ff.rd_ptr + ONE_P;
      cnt = cnt - ONE_N;
    end
    if (do_push) begin
      if (cnt < DEPTH_N) begin
        nxt_s.mem[s_ff.wr_ptr] = SAMPLE;
        nxt_s.wr_ptr = s_ff.wr_ptr + ONE_P;
        cnt = cnt + ONE_N;
      end else if (s_ff.burst_cfg[BIT_STREAM]) begin
        nxt_s.mem[s_ff.wr_ptr] = SAMPLE;
        nxt_s.wr_ptr = s_ff.wr_ptr + ONE_P;
        nxt_s.rd_ptr = s_ff.rd_ptr + ONE_P;
      end
    end
    nxt_s.count = cnt;
  end

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      s_ff <= '0;
      s_ff.if_cfg <= RESET_IF_CFG;
      s_ff.burst_cfg <= RESET_BURST_CFG;
      s_ff.det <= DET_ARMED;
    end else if (CE) begin
      s_ff <= nxt_s;
    end
  end

  assign RD_DATA = s_ff.rdata;
  assign RD_VALID = s_ff.rvalid;
  assign ACC_REFUSED = s_ff.refused;
  // three-wire form to the pin logic
  assign THREE_WIRE = s_ff.if_cfg[BIT_THREE_WIRE];
  assign DETECT_FLAG = s_ff.flag;
  assign INT_CLEAR = s_ff.int_clear;
  assign FIFO_EMPTY = s_ff.count == '0;
  assign FIFO_FULL = s_ff.count == DEPTH_N;
endmodule

// *** tb/fcbw_assertions.sv ***
// Purpose: port-level checks of the configuration bank
// Assumes: one clock domain, checks off while RST is high
// Notes: config bits are hidden, so outputs are tied to their causes
`timescale 1ns/1ps
module fcbw_assertions
  import fcbw_pkg::*;
#(
  parameter int FIFO_DEPTH = FIFO_DEPTH_DEF
)
(
  // clock and reset
  input wire logic CLK,
  input wire logic RST,
  // stimulus
  input wire logic CE,
  input wire access_s ACC,
  input wire logic SAMPLE_VALID,
  input wire logic FIFO_ENABLE,
  input wire logic CONCURRENT_MODE,
  input wire logic SNIFF_EVENT,
  // responses
  input wire logic RD_VALID,
  input wire logic ACC_REFUSED,
  input wire logic THREE_WIRE,
  input wire logic DETECT_FLAG,
  input wire logic INT_CLEAR,
  input wire logic FIFO_EMPTY,
  input wire logic FIFO_FULL
);
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (RST);
  sequence s_read_taken;
    CE && ACC.rd;
  endsequence
  sequence s_one_answer;
    RD_VALID != ACC_REFUSED;
  endsequence
  chk_read_answer: assert property (s_read_taken |=> s_one_answer)
    else $error("read not answered once");
  chk_answer_cause: assert property (RD_VALID |-> $past(ACC.rd))
    else $error("read data without a read");
  chk_quiet_idle: assert property (CE && !ACC.rd && !ACC.wr
    |=> !RD_VALID && !ACC_REFUSED)
    else $error("answer without access");
  chk_flag_cause: assert property ($rose(DETECT_FLAG)
    |-> $past(SNIFF_EVENT && CONCURRENT_MODE))
    else $error("detect flag without event");
  chk_flag_clear: assert property ($fell(DETECT_FLAG)
    |-> INT_CLEAR && $past(ACC.rd || ACC.wr))
    else $error("detect flag cleared without access");
  chk_empty_leave: assert property ($fell(FIFO_EMPTY)
    |-> $past(SAMPLE_VALID && FIFO_ENABLE))
    else $error("fifo filled without sample");
  chk_full_leave: assert property ($fell(FIFO_FULL) |-> $past(ACC.rd))
    else $error("fifo left full without read");
  chk_full_empty: assert property (!(FIFO_EMPTY && FIFO_FULL))
    else $error("fifo full and empty");
  chk_wire_mode: assert property ($changed(THREE_WIRE) |-> $past(ACC.wr))
    else $error("wire mode changed without write");
endmodule

// *** tb/host_access_model.sv ***
// Purpose: host issuing decoded register accesses to the bank
// Assumes: one access per cycle, launched on the falling edge
// Notes: raw lets a scenario break the low-bit write habit on purpose
`timescale 1ns/1ps
module host_access_model
  import fcbw_pkg::*;
(
  // clock
  input wire logic CLK,
  // access bundle
  output access_s acc
);
  logic raw = 1'b0;
  initial acc = '0;
  task automatic op(input logic r, input link_e lk, input logic st,
                    input logic [7:0] a, input logic [7:0] d);
    logic [7:0] w;
    w = (a == ADDR_IF_CFG && !raw) ? (d & IF_CFG_WMASK) : d;
    @(negedge CLK);
    acc = '{start: st, rd: r, wr: !r, link: lk, addr: a, wdata: w};
  endtask
  task automatic idle();
    @(negedge CLK);
    acc = '0;
  endtask
endmodule

// *** tb/tb_feature_config_burst_wrap.sv ***
// Purpose: self-checking bench of the configuration bank
// Assumes: two-wire strap held high; CE dropped once to check freezing
// Notes: read answers are queued by the driver and matched on return
`timescale 1ns/1ps
module tb_feature_config_burst_wrap;
  import fcbw_pkg::*;
  localparam int depth = 4;
  localparam link_e lk2 = LINK_TWO_WIRE;
  localparam link_e lk4 = LINK_FOUR_WIRE;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic smp_valid = 1'b0;
  logic fifo_en = 1'b0;
  logic conc = 1'b0;
  logic sniff = 1'b0;
  logic ce = 1'b1;
  sample_s smp = '0;
  logic [7:0] st1;
  logic [6:0] st2;
  access_s acc;
  logic [7:0] rd_data;
  logic rd_valid, refused, three_wire, flag, int_clear, f_empty, f_full;
  integer seed = 1872;
  int miscompares = 0;
  int n_compared = 0;
  int n_clears = 0;
  logic [8:0] exp_q[$];
  sample_s f[10];

  always #2.5 clk = ~clk;

  host_access_model host_u (.CLK(clk), .acc(acc));
  feature_config_burst_wrap #(.FIFO_DEPTH(depth)) dut_u (
    .CLK(clk), .RST(rst), .CE(ce), .STRAP_TWO_WIRE(1'b1), .ACC(acc),
    .RD_DATA(rd_data), .RD_VALID(rd_valid), .ACC_REFUSED(refused),
    .SAMPLE_VALID(smp_valid), .SAMPLE(smp), .FIFO_ENABLE(fifo_en),
    .CONCURRENT_MODE(conc), .SNIFF_EVENT(sniff), .STATUS_ONE_IN(st1),
    .STATUS_TWO_IN(st2), .THREE_WIRE(three_wire), .DETECT_FLAG(flag),
    .INT_CLEAR(int_clear), .FIFO_EMPTY(f_empty), .FIFO_FULL(f_full));

  task automatic check_byte(string what, logic [8:0] e, logic [8:0] g);
    n_compared++;
    if (g !== e) begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", what, e, g);
    end
  endtask
  task automatic check_level(string what, logic e, logic g);
    check_byte(what, {8'h00, e}, {8'h00, g});
  endtask
  task automatic conclude();
    $display("compared %0d mismatches %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  function automatic logic [7:0] byte_at(logic [7:0] a, sample_s s);
    if (a == ADDR_STATUS_ONE) return st1;
    if (a == ADDR_STATUS_TWO) return {1'b0, st2};
    return s[8 * (a - 8'h02) +: 8];
  endfunction
  task automatic rd(link_e lk, logic [7:0] a, logic [8:0] e);
    exp_q.push_back(e);
    host_u.op(1'b1, lk, 1'b1, a, 8'h00);
  endtask
  task automatic wr(link_e lk, logic [7:0] a, logic [7:0] d);
    host_u.op(1'b0, lk, 1'b1, a, d);
  endtask
  task automatic settle();
    host_u.idle();
    repeat (3) @(negedge clk);
  endtask
  // one burst; k picks the sample shown, one per six bytes
  task automatic burst(logic [7:0] a, int n, int k, logic wrap);
    for (int i = 0; i < n; i++) begin
      exp_q.push_back({1'b0, byte_at(a, f[k + i / 6])});
      host_u.op(1'b1, lk2, i == 0, a, 8'h00);
      a = (a == 8'h09 || (a == 8'h07 && !wrap)) ? 8'h02 : a + 8'h01;
    end
    settle();
  endtask
  task automatic push(sample_s s);
    @(negedge clk);
    smp = s;
    smp_valid = 1'b1;
    @(negedge clk);
    smp_valid = 1'b0;
  endtask
  task automatic detect();
    @(negedge clk);
    sniff = 1'b1;
    @(negedge clk);
    sniff = 1'b0;
    repeat (2) @(negedge clk);
  endtask

  always @(negedge clk) begin
    if (int_clear === 1'b1) begin
      n_clears++;
    end
    if (rd_valid === 1'b1 || refused === 1'b1) begin
      check_byte("read answer", exp_q.size() > 0 ? exp_q.pop_front() : 9'h1FF,
                 {refused, refused ? 8'h00 : rd_data});
    end
  end

  initial begin
    repeat (20000) @(posedge clk);
    miscompares++;
    conclude();
  end

  initial begin
    st1 = 8'($random(seed));
    st2 = 7'($random(seed));
    for (int i = 0; i < 10; i++) begin
      f[i] = sample_s'(48'({$random(seed), $random(seed)}));
    end
    repeat (12) @(posedge clk);
    @(negedge clk);
    rst = 1'b0;
    repeat (4) @(negedge clk);
    rd(lk2, ADDR_IF_CFG, {1'b0, RESET_IF_CFG});
    rd(lk2, ADDR_BURST_CFG, {1'b0, RESET_BURST_CFG});
    rd(lk2, 8'h0A, {1'b0, READ_UNMAPPED});
    settle();
    push(f[0]);
    rd(lk2, ADDR_SAMPLE_FIRST, 9'h000);
    host_u.raw = 1'b1;
    wr(lk2, ADDR_IF_CFG, 8'h67);
    rd(lk2, ADDR_IF_CFG, 9'h060);
    settle();
    host_u.raw = 1'b0;
    check_level("three wire", 1'b1, three_wire);
    wr(lk2, ADDR_IF_CFG, 8'h80);
    rd(lk2, ADDR_IF_CFG, 9'h100);
    rd(lk4, ADDR_IF_CFG, 9'h080);
    wr(lk4, ADDR_IF_CFG, 8'h40);
    rd(lk4, ADDR_IF_CFG, 9'h100);
    settle();
    check_level("three wire", 1'b0, three_wire);
    $display("test select bits done");
    push(f[0]);
    burst(8'h06, 3, 0, 1'b0);
    wr(lk2, ADDR_BURST_CFG, 8'h01);
    burst(8'h08, 3, 0, 1'b1);
    $display("test wrap done");
    fifo_en = 1'b1;
    wr(lk2, ADDR_BURST_CFG, 8'h00);
    settle();
    for (int i = 1; i <= depth + 1; i++) begin
      push(f[i]);
    end
    check_level("fifo full", 1'b1, f_full);
    burst(ADDR_SAMPLE_FIRST, 6, 1, 1'b0);
    check_level("fifo full", 1'b0, f_full);
    wr(lk2, ADDR_BURST_CFG, 8'h02);
    burst(ADDR_SAMPLE_FIRST, 12, 2, 1'b0);
    check_level("fifo empty", 1'b0, f_empty);
    wr(lk2, ADDR_BURST_CFG, 8'h20);
    settle();
    for (int i = 5; i <= 8; i++) begin
      push(f[i]);
    end
    burst(ADDR_SAMPLE_FIRST, 6, 5, 1'b0);
    $display("test fifo done");
    conc = 1'b1;
    wr(lk2, ADDR_IF_CFG, 8'h48);
    settle();
    detect();
    check_level("detect flag", 1'b1, flag);
    push(f[9]);
    check_level("fifo full", 1'b0, f_full);
    rd(lk2, ADDR_STATUS_TWO, {2'b01, st2});
    settle();
    check_level("detect flag", 1'b0, flag);
    detect();
    check_level("detect flag", 1'b0, flag);
    conc = 1'b0;
    wr(lk2, ADDR_IF_CFG, 8'h50);
    wr(lk2, ADDR_BURST_CFG, 8'h10);
    settle();
    conc = 1'b1;
    detect();
    check_level("detect flag", 1'b1, flag);
    push(f[9]);
    check_level("fifo full", 1'b1, f_full);
    rd(lk2, ADDR_STATUS_TWO, {2'b01, st2});
    settle();
    check_level("detect flag", 1'b1, flag);
    wr(lk2, ADDR_STATUS_TWO, 8'h00);
    settle();
    check_level("detect flag", 1'b0, flag);
    ce = 1'b0;
    detect();
    check_level("detect flag", 1'b0, flag);
    ce = 1'b1;
    detect();
    check_level("detect flag", 1'b1, flag);
    $display("test sniff done");
    check_byte("clear pulses", 9'h003, 9'(n_clears));
    check_byte("answers left", 9'h000, {1'b0, 8'(exp_q.size())});
    conclude();
  end
endmodule

bind feature_config_burst_wrap fcbw_assertions #(.FIFO_DEPTH(FIFO_DEPTH))
  chk_u (.CLK(CLK), .RST(RST), .CE(CE), .ACC(ACC),
  .SAMPLE_VALID(SAMPLE_VALID), .FIFO_ENABLE(FIFO_ENABLE),
  .CONCURRENT_MODE(CONCURRENT_MODE), .SNIFF_EVENT(SNIFF_EVENT),
  .RD_VALID(RD_VALID), .ACC_REFUSED(ACC_REFUSED), .THREE_WIRE(THREE_WIRE),
  .DETECT_FLAG(DETECT_FLAG), .INT_CLEAR(INT_CLEAR),
  .FIFO_EMPTY(FIFO_EMPTY), .FIFO_FULL(FIFO_FULL));
